/* acs_ctrl.sv */
// scan control and register logic of the eight-channel converter, ahb-lite slave
`timescale 1ns/1ns
`include "acs_map.svh"

module acs_ctrl (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // converter core
   output logic conv_start,
   output logic conv_abort,
   output logic [2:0] conv_channel,
   output logic [3:0] conv_divisor,
   input wire logic conv_done,
   input wire logic [9:0] conv_result,
   // pins and trigger
   input wire logic [7:0] analog_pins,
   input wire logic external_trigger_in,
   output logic capture_pulse,
   output logic scan_done_irq
);

   // ********************************
   // helper functions
   // ********************************

   // lowest selected channel at or above a start index, found bit on top
   function automatic logic [3:0] next_chan(input logic [7:0] set, input logic [3:0] from);
      logic [3:0] res;
      res = 4'h0;
      for (int i = 7; i >= 0; i--) begin
         if (set[i] && (4'(i) >= from)) begin
            res = {1'b1, 3'(i)};
         end
      end
      return res;
   endfunction

   // divisor from the two prescale bits
   function automatic logic [3:0] divisor_of(input logic [1:0] code);
      return {1'b0, code, 1'b0} + 4'h2;
   endfunction

   // ********************************
   // bus slave
   // ********************************

   logic wr_pend_r;
   logic rd_pend_r;
   logic rd_load_r;
   logic [7:0] idx_r;
   logic [31:0] hrdata_r;
   logic addr_ok;

   assign addr_ok = hsel && hready && (htrans == `ACS_HTRANS_NONSEQ);
   assign hresp = 1'b0;
   // reads take one wait state so that a write just before is visible
   assign hreadyout = !rd_pend_r;
   assign hrdata = hrdata_r;

   // address phase capture
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         rd_load_r <= 1'b0;
         idx_r <= 8'h00;
      end else begin
         wr_pend_r <= addr_ok && hwrite;
         rd_pend_r <= addr_ok && !hwrite;
         rd_load_r <= rd_pend_r;
         if (addr_ok) begin
            idx_r <= haddr[9:2];
         end
      end
   end

   logic wr_ctrl;
   logic wr_sel;
   logic rd_low;
   assign wr_ctrl = wr_pend_r && (idx_r == `ACS_IDX_CTRL);
   assign wr_sel = wr_pend_r && (idx_r == `ACS_IDX_SEL);
   assign rd_low = rd_pend_r && idx_r[7] && (idx_r[3:0] == `ACS_LOW_NIB);

   // ********************************
   // registers
   // ********************************

   logic [1:0] pre_r;
   logic cont_r;
   logic rise_en_r;
   logic fall_en_r;
   logic done_r;
   logic sst_r;
   logic [7:0] sel_r;
   logic [9:0] result_mem [8];
   logic [1:0] high_latch_r;

   // plain control fields and scan-select
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pre_r <= 2'(`ACS_CTRL_RST >> `ACS_PRE_LO);
         cont_r <= 1'b0;
         rise_en_r <= 1'b0;
         fall_en_r <= 1'b0;
         sel_r <= `ACS_SEL_RST;
      end else begin
         if (wr_ctrl) begin
            pre_r <= hwdata[`ACS_PRE_HI:`ACS_PRE_LO];
            cont_r <= hwdata[`ACS_CONT_BIT];
            rise_en_r <= hwdata[`ACS_RISE_BIT];
            fall_en_r <= hwdata[`ACS_FALL_BIT];
         end
         if (wr_sel) begin
            sel_r <= hwdata[7:0];
         end
      end
   end

   // divisor to the converter core
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         conv_divisor <= 4'h2;
      end else begin
         conv_divisor <= divisor_of(pre_r);
      end
   end

   // read data; pins read live, and a low-byte result read also latches the high bits
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hrdata_r <= 32'h0000_0000;
      end else if (rd_pend_r) begin
         unique case (1'b1)
            idx_r == `ACS_IDX_PINS: hrdata_r <= {24'h00_0000, analog_pins};
            idx_r == `ACS_IDX_CTRL: hrdata_r <= {24'h00_0000, pre_r, 1'b0, done_r,
                                                 sst_r, cont_r, rise_en_r, fall_en_r};
            idx_r == `ACS_IDX_SEL: hrdata_r <= {24'h00_0000, sel_r};
            idx_r == `ACS_IDX_RSH: hrdata_r <= {30'h0000_0000, high_latch_r};
            rd_low: hrdata_r <= {24'h00_0000, result_mem[idx_r[6:4]][7:0]};
            default: hrdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // ********************************
   // trigger synchroniser and edges
   // ********************************

   logic trig_s1_r;
   logic trig_s2_r;
   logic trig_d_r;
   logic rise_ev;
   logic fall_ev;

   // two-stage sync then one delay for edge detection
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         trig_s1_r <= 1'b0;
         trig_s2_r <= 1'b0;
         trig_d_r <= 1'b0;
      end else begin
         trig_s1_r <= external_trigger_in;
         trig_s2_r <= trig_s1_r;
         trig_d_r <= trig_s2_r;
      end
   end

   assign rise_ev = rise_en_r && trig_s2_r && !trig_d_r;
   assign fall_ev = fall_en_r && !trig_s2_r && trig_d_r;

   // capture pulse on each enabled edge
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         capture_pulse <= 1'b0;
      end else begin
         capture_pulse <= rise_ev || fall_ev;
      end
   end

   // ********************************
   // scan sequencer
   // ********************************

   acs_pkg::acs_state_type state_r;
   logic [7:0] set_r;
   logic [2:0] ch_r;
   logic start_req;
   logic start_ok;
   logic abort_req;
   logic [3:0] first;
   logic [3:0] nxt;
   logic loop_end;

   // start from software or trigger, refused while running or empty
   assign start_req = (wr_ctrl && hwdata[`ACS_SST_BIT]) || rise_ev || fall_ev;
   assign start_ok = start_req && !sst_r && (sel_r != 8'h00);
   assign abort_req = wr_ctrl && !hwdata[`ACS_SST_BIT] && sst_r;
   assign first = next_chan(sel_r, 4'h0);
   assign nxt = next_chan(set_r, {1'b0, ch_r} + 4'h1);
   assign loop_end = (state_r == acs_pkg::ACS_WAIT) && conv_done && !nxt[3] && !abort_req;

   // state, channel set and current channel
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= acs_pkg::ACS_IDLE;
         set_r <= 8'h00;
         ch_r <= 3'h0;
      end else begin
         unique case (state_r)
            acs_pkg::ACS_IDLE: begin
               if (start_ok) begin
                  set_r <= sel_r;
                  ch_r <= first[2:0];
                  state_r <= acs_pkg::ACS_ISSUE;
               end
            end
            acs_pkg::ACS_ISSUE: begin
               if (abort_req) begin
                  state_r <= acs_pkg::ACS_IDLE;
               end else begin
                  state_r <= acs_pkg::ACS_WAIT;
               end
            end
            acs_pkg::ACS_WAIT: begin
               if (abort_req) begin
                  state_r <= acs_pkg::ACS_IDLE;
               end else if (conv_done && nxt[3]) begin
                  ch_r <= nxt[2:0];
                  state_r <= acs_pkg::ACS_ISSUE;
               end else if (loop_end && cont_r && (sel_r != 8'h00)) begin
                  set_r <= sel_r;
                  ch_r <= first[2:0];
                  state_r <= acs_pkg::ACS_ISSUE;
               end else if (loop_end) begin
                  state_r <= acs_pkg::ACS_IDLE;
               end
            end
         endcase
      end
   end

   // start-and-status bit
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sst_r <= 1'b0;
      end else if (start_ok) begin
         sst_r <= 1'b1;
      end else if (abort_req) begin
         sst_r <= 1'b0;
      end else if (loop_end && !(cont_r && (sel_r != 8'h00))) begin
         sst_r <= 1'b0;
      end
   end

   // completion flag: hardware set wins over software clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         done_r <= 1'b0;
      end else if (loop_end) begin
         done_r <= 1'b1;
      end else if (wr_ctrl && !hwdata[`ACS_DONE_BIT]) begin
         done_r <= 1'b0;
      end
   end

   assign scan_done_irq = done_r;

   // converter strobes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         conv_start <= 1'b0;
         conv_abort <= 1'b0;
         conv_channel <= 3'h0;
      end else begin
         conv_start <= (state_r == acs_pkg::ACS_ISSUE) && !abort_req;
         conv_abort <= abort_req;
         conv_channel <= ch_r;
      end
   end

   // result storage, never reset
   always_ff @(posedge mclk) begin
      if ((state_r == acs_pkg::ACS_WAIT) && conv_done && !abort_req) begin
         result_mem[ch_r] <= conv_result;
      end
   end

   // high bits latched on a low-byte read
   always_ff @(posedge mclk) begin
      if (rd_low) begin
         high_latch_r <= result_mem[idx_r[6:4]][9:8];
      end
   end

   // ********************************
   // assertions
   // ********************************

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence rd_high_s;
      rd_pend_r && (idx_r == `ACS_IDX_RSH);
   endsequence

   high_read_a: assert property (rd_high_s |=> (hrdata[7:2] == 6'h00)
      && (hrdata[1:0] == $past(high_latch_r))) else $error("high bits read wrong");
   empty_start_a: assert property ((start_req && !sst_r && sel_r == 8'h00)
      |=> !sst_r) else $error("start accepted with empty selection");
   chan_sel_a: assert property (conv_start |-> set_r[conv_channel])
      else $error("unselected channel converted");
   done_set_a: assert property (loop_end |=> done_r && scan_done_irq)
      else $error("completion flag not set");
   sw_set_a: assert property ((wr_ctrl && !done_r && !loop_end) |=> !done_r)
      else $error("software set the completion flag");
   one_shot_a: assert property ((loop_end && !cont_r) |=> !sst_r ##1 !conv_start)
      else $error("one-time scan kept running");
   cont_loop_a: assert property ((loop_end && cont_r && sel_r != 8'h00)
      |=> sst_r ##1 (conv_start || conv_abort)) else $error("continuous scan did not repeat");
   busy_ignore_a: assert property ((start_req && sst_r && !abort_req && !loop_end)
      |=> sst_r && $stable(set_r)) else $error("start while busy not ignored");
   abort_a: assert property (abort_req |=> conv_abort && !sst_r
      && (state_r == acs_pkg::ACS_IDLE)) else $error("abort not taken");
   capture_a: assert property ((rise_ev || fall_ev) |=> capture_pulse ##1 !capture_pulse)
      else $error("capture pulse wrong");
   divisor_a: assert property (wr_ctrl |=> ##1 (conv_divisor == divisor_of($past(pre_r))))
      else $error("divisor mismatch");

endmodule

/* acs_map.svh */
// register indices, field positions, reset values and bus constants for the scan control
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// register indices; byte address is four times the index
`define ACS_IDX_PINS 8'hC7
`define ACS_IDX_CTRL 8'hD7
`define ACS_IDX_SEL 8'hE7
`define ACS_IDX_RSH 8'hF7
// low-byte results sit at index 8'h86 + 8'h10 * channel
`define ACS_LOW_NIB 4'h6
// control register fields
`define ACS_PRE_HI 7
`define ACS_PRE_LO 6
`define ACS_RSV_BIT 5
`define ACS_DONE_BIT 4
`define ACS_SST_BIT 3
`define ACS_CONT_BIT 2
`define ACS_RISE_BIT 1
`define ACS_FALL_BIT 0
// reset values
`define ACS_CTRL_RST 8'h00
`define ACS_SEL_RST 8'h00
// ahb transfer type
`define ACS_HTRANS_NONSEQ 2'h2
`endif

/* acs_pkg.sv */
// types shared by the scan control block
package acs_pkg;
   // scan sequencer states, one-hot
   typedef enum logic [2:0] {
      ACS_IDLE = 3'b001,
      ACS_ISSUE = 3'b010,
      ACS_WAIT = 3'b100
   } acs_state_type;
endpackage

/* acs_core_model.sv */
// behavioural converter core answering the scan control block
`timescale 1ns/1ns

module acs_core_model #(
   parameter int DLY = 3
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // requests from the scan control
   input wire logic conv_start,
   input wire logic conv_abort,
   input wire logic [2:0] conv_channel,
   // answer
   output logic conv_done,
   output logic [9:0] conv_result
);
   int cnt;

   // one done pulse per start unless aborted, result unique per channel; junk between
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         conv_done <= 1'b0;
         conv_result <= 10'h155;
      end else begin
         conv_done <= 1'b0;
         conv_result <= ~conv_result; // no stale value outside done
         if (conv_abort) begin
            cnt <= 0;
         end else if (conv_start) begin
            cnt <= DLY;
         end else if (cnt == 1) begin
            cnt <= 0;
            conv_done <= 1'b1;
            conv_result <= {~conv_channel[1:0], 5'h15, conv_channel};
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule

/* acs_tb.sv */
// self-checking testbench of the scan control block
`timescale 1ns/1ns
`include "acs_map.svh"

module testbench;
   logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic conv_start, conv_abort, conv_done, trig, capture_pulse, scan_done_irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, conv_channel;
   logic [3:0] conv_divisor;
   logic [9:0] conv_result, e;
   logic [7:0] analog_pins, rd;
   logic [2:0] q[$];
   int error_cnt = 0, n_checks = 0, ncap = 0, nab = 0, cyc = 0;
   int chs[4] = '{0, 2, 5, 7};

   assign hready = hreadyout;
   acs_ctrl u_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .conv_start(conv_start),
      .conv_abort(conv_abort), .conv_channel(conv_channel), .conv_divisor(conv_divisor),
      .conv_done(conv_done), .conv_result(conv_result), .analog_pins(analog_pins),
      .external_trigger_in(trig), .capture_pulse(capture_pulse),
      .scan_done_irq(scan_done_irq));
   acs_core_model u_core (.mclk(mclk), .rst(rst), .conv_start(conv_start),
      .conv_abort(conv_abort), .conv_channel(conv_channel), .conv_done(conv_done),
      .conv_result(conv_result));

   // clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // watch the core link, count captures, cut a hang short
   always @(negedge mclk) begin
      cyc <= cyc + 1;
      if (conv_start === 1'b1) q.push_back(conv_channel);
      if (capture_pulse === 1'b1) ncap <= ncap + 1;
      if (conv_abort === 1'b1) nab <= nab + 1;
      if (cyc == 20000) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, cyc, 0);
         give_verdict();
      end
   end

   // *****
   // bus and compare tasks
   // *****
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // hready sampled just before the rising edge, read data with it
   task automatic edge_rdy();
      logic r;
      do begin
         @(negedge mclk);
         r = hready;
         rd = hrdata[7:0];
         @(posedge mclk);
      end while (r !== 1'b1);
   endtask

   task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'h0};
      htrans <= `ACS_HTRANS_NONSEQ;
      hwrite <= wr;
      edge_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      edge_rdy();
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(idx, 1'b1, d);
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      bus(idx, 1'b0, 8'h00);
      chk({2'h0, rd}, {2'h0, exp});
   endtask

   task automatic wait_irq();
      @(negedge mclk);
      for (int n = 0; n < 400 && scan_done_irq !== 1'b1; n++) @(negedge mclk);
      chk(10'(scan_done_irq), 10'h1);
      @(posedge mclk);
   endtask

   function automatic logic [9:0] res(input logic [2:0] c);
      return {~c[1:0], 5'h15, c};
   endfunction

   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // *****
   // main sequence
   // *****
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      analog_pins = 8'h5A;
      trig = 1'b0;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rdchk(`ACS_IDX_CTRL, 8'h00);
      rdchk(`ACS_IDX_SEL, 8'h00);
      chk(10'(conv_divisor), 10'h2);
      for (int m = 0; m < 4; m++) begin
         wr(`ACS_IDX_CTRL, {m[1:0], 6'h00});
         repeat (2) @(posedge mclk);
         chk(10'(conv_divisor), 10'(2 * m + 2));
      end
      rdchk(`ACS_IDX_PINS, 8'h5A);
      analog_pins <= 8'hC3; // pins move only while idle
      rdchk(`ACS_IDX_PINS, 8'hC3);
      rdchk(8'h10, 8'h00);
      chk(10'(hresp), 10'h0);
      // start refused with empty channel set
      wr(`ACS_IDX_CTRL, 8'h08);
      repeat (8) @(posedge mclk);
      chk(10'(q.size()), 10'h0);
      rdchk(`ACS_IDX_CTRL, 8'h00);
      // one-time scan, repeated start ignored, pin read mid-scan
      wr(`ACS_IDX_SEL, 8'hA5);
      wr(`ACS_IDX_CTRL, 8'h08);
      wr(`ACS_IDX_CTRL, 8'h08);
      rdchk(`ACS_IDX_PINS, 8'hC3);
      wait_irq();
      rdchk(`ACS_IDX_CTRL, 8'h10);
      chk(10'(scan_done_irq), 10'h1);
      chk(10'(q.size()), 10'h4);
      foreach (chs[i]) begin
         chk(10'(q[i]), 10'(chs[i]));
         e = res(3'(chs[i]));
         rdchk(8'(8'h86 + 8'h10 * chs[i]), e[7:0]);
         rdchk(`ACS_IDX_RSH, {6'h0, e[9:8]});
      end
      // flag cleared by software, never set by it
      wr(`ACS_IDX_CTRL, 8'h00);
      rdchk(`ACS_IDX_CTRL, 8'h00);
      chk(10'(scan_done_irq), 10'h0);
      wr(`ACS_IDX_CTRL, 8'h10);
      rdchk(`ACS_IDX_CTRL, 8'h00);
      // continuous scan, channel set changed mid-loop, then abort
      q.delete();
      wr(`ACS_IDX_SEL, 8'h03);
      wr(`ACS_IDX_CTRL, 8'h0C);
      wr(`ACS_IDX_SEL, 8'h80);
      wait_irq();
      repeat (30) @(posedge mclk);
      chk(10'(q[0]), 10'h0);
      chk(10'(q[1]), 10'h1);
      chk(10'(q[2]), 10'h7);
      rdchk(`ACS_IDX_CTRL, 8'h1C);
      wr(`ACS_IDX_CTRL, 8'h00);
      repeat (3) @(posedge mclk);
      chk(10'(nab != 0), 10'h1);
      rdchk(`ACS_IDX_CTRL, 8'h00);
      // trigger edges, each enable alone
      q.delete();
      wr(`ACS_IDX_SEL, 8'h01);
      wr(`ACS_IDX_CTRL, 8'h02);
      trig <= 1'b1;
      wait_irq();
      chk(10'(ncap), 10'h1);
      chk(10'(q.size()), 10'h1);
      trig <= 1'b0;
      repeat (10) @(posedge mclk);
      chk(10'(ncap), 10'h1);
      wr(`ACS_IDX_CTRL, 8'h01);
      trig <= 1'b1;
      repeat (10) @(posedge mclk);
      trig <= 1'b0;
      wait_irq();
      chk(10'(ncap), 10'h2);
      chk(10'(q.size()), 10'h2);
      give_verdict();
   end
endmodule
